//--- hw/conditional_trap_evaluator.sv
// conditional trap evaluator: decodes trap instructions and raises a trap
// Operation
// [RULE1] ge unsigned imm: sign-extend, unsigned compare
// [RULE2] ge unsigned reg: unsigned compare, trap ge
// [RULE3] lt signed reg: signed compare, trap lt
// [RULE4] both lt imm forms: signed compare
// [RULE5] lt unsigned reg: unsigned compare, trap lt
// [RULE6] ne reg, zero opcode: trap when differ
// [RULE7] ne imm: sign-extend, trap when differ
// [RULE8] ten-bit code field ignored in evaluation
// [RULE9] trap precise, no register write, else nop
`timescale 1ns/100ps
`include "trap_eval_defines.svh"
module conditional_trap_evaluator
  import trap_eval_pkg::*;
#(
  parameter int XLEN = 64
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic issue_valid,
  input wire logic [31:0] instr_word,
  input wire logic [XLEN-1:0] first_source_reg,
  input wire logic [XLEN-1:0] second_source_reg,
  output logic is_trap_instr,
  output logic trap_taken,
  output logic general_register_write_en
);

  // --------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------
  // recognised trap words map to a compare kind, anything else to cmp_none
  function automatic cmp_kind_t decode_kind(input logic [31:0] iw);
    cmp_kind_t k;
    k = cmp_none;
    // code field bits 15..6 never reach the decode
    if (iw[`OPC_MSB:`OPC_LSB] == `OPC_FUNC_CLASS) begin // RULE8
      case (iw[`FN_MSB:`FN_LSB])
        `FN_GE_S_REG: k = cmp_ge_s;
        `FN_GE_U_REG: k = cmp_ge_u; // RULE2
        `FN_LT_S_REG: k = cmp_lt_s; // RULE3
        `FN_LT_U_REG: k = cmp_lt_u; // RULE5
        `FN_EQ_REG: k = cmp_eq;
        `FN_NE_REG: k = cmp_ne; // RULE6
        default: k = cmp_none;
      endcase
    end else if (iw[`OPC_MSB:`OPC_LSB] == `OPC_IMM_CLASS) begin
      case (iw[`SEL_MSB:`SEL_LSB])
        `SEL_GE_S_IMM: k = cmp_ge_s;
        `SEL_GE_U_IMM: k = cmp_ge_u; // RULE1
        `SEL_LT_S_IMM: k = cmp_lt_s; // RULE4
        // signed compare despite the unsigned name: software must not expect unsigned order here
        `SEL_LT_U_IMM: k = cmp_lt_s; // RULE4
        `SEL_EQ_IMM: k = cmp_eq;
        `SEL_NE_IMM: k = cmp_ne; // RULE7
        default: k = cmp_none;
      endcase
    end
    return k;
  endfunction : decode_kind

  // --------------------------------------------------------------------
  // operand select and compare
  // --------------------------------------------------------------------
  cmp_kind_t kind;
  logic imm_form;
  logic [XLEN-1:0] imm_ext;
  logic [XLEN-1:0] rhs;
  logic cond_true;

  // immediate forms use the sign-extended 16-bit field
  assign kind = decode_kind(instr_word);
  assign imm_form = (instr_word[`OPC_MSB:`OPC_LSB] == `OPC_IMM_CLASS);
  assign imm_ext = {{(XLEN-`IMM_WIDTH){instr_word[`IMM_MSB]}}, instr_word[`IMM_MSB:0]}; // RULE1 RULE4 RULE7
  assign rhs = imm_form ? imm_ext : second_source_reg;

  // compare per kind; signed and unsigned share one operand path
  always_comb begin
    case (kind)
      cmp_eq: cond_true = (first_source_reg == rhs);
      cmp_ne: cond_true = (first_source_reg != rhs); // RULE6 RULE7
      cmp_ge_s: cond_true = ($signed(first_source_reg) >= $signed(rhs));
      cmp_ge_u: cond_true = (first_source_reg >= rhs); // RULE1 RULE2
      cmp_lt_s: cond_true = ($signed(first_source_reg) < $signed(rhs)); // RULE3 RULE4
      cmp_lt_u: cond_true = (first_source_reg < rhs); // RULE5
      default: cond_true = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------
  // result registers
  // --------------------------------------------------------------------
  // class flag: a recognised trap word was taken at this edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      is_trap_instr <= 1'b0;
    end else begin
      is_trap_instr <= issue_valid && (kind != cmp_none);
    end
  end

  // one-cycle pulse, registered so the exception stage sees a clean edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trap_taken <= 1'b0;
    end else begin
      trap_taken <= issue_valid && (kind != cmp_none) && cond_true; // RULE9
    end
  end

  // trap instructions never write a general register
  assign general_register_write_en = 1'b0; // RULE9

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  // ge unsigned imm: unsigned order against the sign-extended bound
  property p_ge_unsigned_imm;
    @(posedge clk) disable iff (!rst_b)
      (issue_valid && instr_word[`OPC_MSB:`OPC_LSB] == `OPC_IMM_CLASS &&
       instr_word[`SEL_MSB:`SEL_LSB] == `SEL_GE_U_IMM)
      |=> (trap_taken == ($past(first_source_reg) >= $past(imm_ext)));
  endproperty
  a_ge_unsigned_imm: assert property (p_ge_unsigned_imm) else $error("ge unsigned imm wrong"); // RULE1

  // ge unsigned reg: plain unsigned order of both operands
  property p_ge_unsigned_reg;
    @(posedge clk) disable iff (!rst_b)
      (issue_valid && instr_word[`OPC_MSB:`OPC_LSB] == `OPC_FUNC_CLASS &&
       instr_word[`FN_MSB:`FN_LSB] == `FN_GE_U_REG)
      |=> (trap_taken == ($past(first_source_reg) >= $past(second_source_reg)));
  endproperty
  a_ge_unsigned_reg: assert property (p_ge_unsigned_reg) else $error("ge unsigned reg wrong"); // RULE2

  // lt signed reg: equal operands are never strictly less
  property p_lt_signed_reg;
    @(posedge clk) disable iff (!rst_b)
      (issue_valid && instr_word[`OPC_MSB:`OPC_LSB] == `OPC_FUNC_CLASS &&
       instr_word[`FN_MSB:`FN_LSB] == `FN_LT_S_REG &&
       first_source_reg == second_source_reg) |=> !trap_taken;
  endproperty
  a_lt_signed_reg: assert property (p_lt_signed_reg) else $error("lt signed reg trapped on equal"); // RULE3

  // lt signed reg: full two's-complement order
  property p_lt_signed_reg_order;
    @(posedge clk) disable iff (!rst_b)
      (issue_valid && instr_word[`OPC_MSB:`OPC_LSB] == `OPC_FUNC_CLASS &&
       instr_word[`FN_MSB:`FN_LSB] == `FN_LT_S_REG)
      |=> (trap_taken == ($signed($past(first_source_reg)) < $signed($past(second_source_reg))));
  endproperty
  a_lt_signed_reg_order: assert property (p_lt_signed_reg_order) else $error("lt signed reg order wrong"); // RULE3

  // both lt imm selectors compare signed
  property p_lt_imm;
    @(posedge clk) disable iff (!rst_b)
      (issue_valid && instr_word[`OPC_MSB:`OPC_LSB] == `OPC_IMM_CLASS &&
       (instr_word[`SEL_MSB:`SEL_LSB] == `SEL_LT_S_IMM || instr_word[`SEL_MSB:`SEL_LSB] == `SEL_LT_U_IMM))
      |=> (trap_taken == ($signed($past(first_source_reg)) < $signed($past(imm_ext))));
  endproperty
  a_lt_imm: assert property (p_lt_imm) else $error("lt imm wrong"); // RULE4

  // lt unsigned reg: plain unsigned order
  property p_lt_unsigned_reg;
    @(posedge clk) disable iff (!rst_b)
      (issue_valid && instr_word[`OPC_MSB:`OPC_LSB] == `OPC_FUNC_CLASS &&
       instr_word[`FN_MSB:`FN_LSB] == `FN_LT_U_REG)
      |=> (trap_taken == ($past(first_source_reg) < $past(second_source_reg)));
  endproperty
  a_lt_unsigned_reg: assert property (p_lt_unsigned_reg) else $error("lt unsigned reg wrong"); // RULE5

  // ne reg: any differing bit traps
  property p_ne_reg;
    @(posedge clk) disable iff (!rst_b)
      (issue_valid && instr_word[`OPC_MSB:`OPC_LSB] == `OPC_FUNC_CLASS &&
       instr_word[`FN_MSB:`FN_LSB] == `FN_NE_REG)
      |=> (trap_taken == ($past(first_source_reg) != $past(second_source_reg)));
  endproperty
  a_ne_reg: assert property (p_ne_reg) else $error("ne reg wrong"); // RULE6

  // ne imm: compared against the sign-extended bound
  property p_ne_imm;
    @(posedge clk) disable iff (!rst_b)
      (issue_valid && instr_word[`OPC_MSB:`OPC_LSB] == `OPC_IMM_CLASS &&
       instr_word[`SEL_MSB:`SEL_LSB] == `SEL_NE_IMM)
      |=> (trap_taken == ($past(first_source_reg) != $past(imm_ext)));
  endproperty
  a_ne_imm: assert property (p_ne_imm) else $error("ne imm wrong"); // RULE7

  // code bits cleared must give the same decode
  property p_code_ignored;
    @(posedge clk) disable iff (!rst_b)
      (issue_valid && instr_word[`OPC_MSB:`OPC_LSB] == `OPC_FUNC_CLASS)
      |-> (kind == decode_kind({instr_word[31:16], 10'h000, instr_word[5:0]}));
  endproperty
  a_code_ignored: assert property (p_code_ignored) else $error("code field affects decode"); // RULE8

  // a trap only follows a taken trap word and never writes a register
  property p_trap_needs_issue;
    @(posedge clk) disable iff (!rst_b)
      trap_taken |-> ($past(issue_valid) && is_trap_instr && !general_register_write_en);
  endproperty
  a_trap_needs_issue: assert property (p_trap_needs_issue) else $error("trap without trap issue"); // RULE9

  // an idle cycle leaves both flags low at the next edge
  property p_no_issue_no_trap;
    @(posedge clk) disable iff (!rst_b)
      !issue_valid |=> (!trap_taken && !is_trap_instr);
  endproperty
  a_no_issue_no_trap: assert property (p_no_issue_no_trap) else $error("flag raised without issue"); // RULE9

  // words outside both trap classes complete as a no-operation
  property p_other_word_quiet;
    @(posedge clk) disable iff (!rst_b)
      (issue_valid && instr_word[`OPC_MSB:`OPC_LSB] != `OPC_FUNC_CLASS &&
       instr_word[`OPC_MSB:`OPC_LSB] != `OPC_IMM_CLASS) |=> (!trap_taken && !is_trap_instr);
  endproperty
  a_other_word_quiet: assert property (p_other_word_quiet) else $error("non-trap word raised a flag"); // RULE9

  // the ge unsigned, lt signed, lt unsigned and ne register-form trap words are flagged as trap instructions
  property p_class_flag;
    @(posedge clk) disable iff (!rst_b)
      (issue_valid && instr_word[`OPC_MSB:`OPC_LSB] == `OPC_FUNC_CLASS &&
       instr_word[`FN_MSB:`FN_LSB] inside {`FN_GE_U_REG, `FN_LT_S_REG, `FN_LT_U_REG, `FN_NE_REG})
      |=> is_trap_instr;
  endproperty
  a_class_flag: assert property (p_class_flag) else $error("trap word not flagged"); // RULE9

endmodule : conditional_trap_evaluator

//--- hw/trap_eval_defines.svh
// constants for the conditional trap evaluator
`ifndef TRAP_EVAL_DEFINES_SVH
`define TRAP_EVAL_DEFINES_SVH
// primary opcode classes that carry trap words
`define OPC_FUNC_CLASS 6'h00
`define OPC_IMM_CLASS 6'h01
// function codes of the register forms
`define FN_GE_S_REG 6'h30
`define FN_GE_U_REG 6'h31
`define FN_LT_S_REG 6'h32
`define FN_LT_U_REG 6'h33
`define FN_EQ_REG 6'h34
`define FN_NE_REG 6'h36
// selector codes of the immediate forms
`define SEL_GE_S_IMM 5'h08
`define SEL_GE_U_IMM 5'h09
`define SEL_LT_S_IMM 5'h0A
`define SEL_LT_U_IMM 5'h0B
`define SEL_EQ_IMM 5'h0C
`define SEL_NE_IMM 5'h0E
// instruction field positions
`define OPC_MSB 31
`define OPC_LSB 26
`define SEL_MSB 20
`define SEL_LSB 16
`define FN_MSB 5
`define FN_LSB 0
`define IMM_MSB 15
`define IMM_WIDTH 16
`endif

//--- hw/trap_eval_pkg.sv
// types for the conditional trap evaluator
package trap_eval_pkg;
  typedef enum logic [2:0] {
    cmp_none = 3'b000,
    cmp_eq = 3'b001,
    cmp_ne = 3'b010,
    cmp_ge_s = 3'b011,
    cmp_ge_u = 3'b100,
    cmp_lt_s = 3'b101,
    cmp_lt_u = 3'b110
  } cmp_kind_t;
endpackage : trap_eval_pkg

//--- verif/conditional_trap_evaluator_tb.sv
// self-checking bench for the conditional trap evaluator
`timescale 1ns/100ps
`include "trap_eval_defines.svh"
module conditional_trap_evaluator_tb;
  import trap_eval_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic issue_valid, is_trap_instr, trap_taken, general_register_write_en;
  logic [31:0] instr_word;
  logic [63:0] op_a, op_b;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  issue_model PART (.clk(clk), .issue_valid(issue_valid), .instr_word(instr_word), .op_a(op_a), .op_b(op_b));
  conditional_trap_evaluator #(.XLEN(64)) DUT (.clk(clk), .rst_b(rst_b), .issue_valid(issue_valid),
    .instr_word(instr_word), .first_source_reg(op_a), .second_source_reg(op_b),
    .is_trap_instr(is_trap_instr), .trap_taken(trap_taken), .general_register_write_en(general_register_write_en));
  // -----------------------------------------
  // helpers
  // -----------------------------------------
  task automatic chk(input string what, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, g);
    end
  endtask : chk
  // answer lands exactly one edge after issue
  task automatic run(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b, input logic t, input logic k);
    PART.issue(w, a, b);
    chk("is_trap_instr", k, is_trap_instr);
    chk("trap_taken", t, trap_taken);
    chk("general_register_write_en", 1'b0, general_register_write_en);
  endtask : run
  // trap word shown with valid low must leave both flags low
  task automatic quiet(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b);
    PART.stall(w, a, b);
    chk("is_trap_instr stalled", 1'b0, is_trap_instr);
    chk("trap_taken stalled", 1'b0, trap_taken);
  endtask : quiet
  task automatic rest(input string name);
    PART.idle();
    chk("trap_taken idle", 1'b0, trap_taken);
    $display("%s done", name);
  endtask : rest
  function automatic logic [31:0] rw(input logic [5:0] fn, input logic [9:0] code);
    return {`OPC_FUNC_CLASS, 10'h000, code, fn};
  endfunction : rw
  function automatic logic [31:0] iw(input logic [4:0] sel, input logic [15:0] imm);
    return {`OPC_IMM_CLASS, 5'h00, sel, imm};
  endfunction : iw
  // register forms back to back, sign bit decides signedness
  task automatic t_reg();
    run(rw(`FN_GE_U_REG, 10'h000), '1, 64'h1, 1'b1, 1'b1);
    run(rw(`FN_GE_U_REG, 10'h000), 64'h1, '1, 1'b0, 1'b1);
    run(rw(`FN_LT_S_REG, 10'h000), '1, 64'h1, 1'b1, 1'b1);
    run(rw(`FN_LT_S_REG, 10'h000), 64'h5, 64'h5, 1'b0, 1'b1);
    run(rw(`FN_LT_U_REG, 10'h000), '1, 64'h1, 1'b0, 1'b1);
    run(rw(`FN_LT_U_REG, 10'h000), 64'h1, '1, 1'b1, 1'b1);
    run(rw(`FN_NE_REG, 10'h000), 64'h8000000000000000, 64'h0, 1'b1, 1'b1);
    run(rw(`FN_NE_REG, 10'h000), '1, '1, 1'b0, 1'b1);
    rest("t_reg");
  endtask : t_reg
  // immediate 0xFFFF must extend to all ones
  task automatic t_imm();
    run(iw(`SEL_GE_U_IMM, 16'hFFFF), 64'hFFFF, 64'h0, 1'b0, 1'b1);
    run(iw(`SEL_GE_U_IMM, 16'hFFFF), '1, 64'h0, 1'b1, 1'b1);
    run(iw(`SEL_GE_U_IMM, 16'h7FFF), 64'h8000, 64'h0, 1'b1, 1'b1);
    run(iw(`SEL_LT_S_IMM, 16'hFFFF), 64'hFFFFFFFFFFFFFFFE, 64'h0, 1'b1, 1'b1);
    run(iw(`SEL_LT_S_IMM, 16'hFFFF), 64'h0, 64'h0, 1'b0, 1'b1);
    run(iw(`SEL_LT_U_IMM, 16'hFFFF), 64'hFFFFFFFFFFFFFFFE, 64'h0, 1'b1, 1'b1);
    run(iw(`SEL_LT_U_IMM, 16'hFFFF), 64'hFFFF, 64'h0, 1'b0, 1'b1);
    run(iw(`SEL_NE_IMM, 16'hFFFF), 64'hFFFF, 64'h0, 1'b1, 1'b1);
    run(iw(`SEL_NE_IMM, 16'hFFFF), '1, 64'h0, 1'b0, 1'b1);
    run(iw(`SEL_NE_IMM, 16'h8000), 64'h8000, 64'h0, 1'b1, 1'b1);
    rest("t_imm");
  endtask : t_imm
  // code bits set must not sway the outcome
  task automatic t_code();
    run(rw(`FN_NE_REG, 10'h3FF), 64'h7, 64'h7, 1'b0, 1'b1);
    run(rw(`FN_GE_U_REG, 10'h2AA), 64'h2, 64'h2, 1'b1, 1'b1);
    run(rw(`FN_LT_S_REG, 10'h155), 64'h3, 64'h4, 1'b1, 1'b1);
    rest("t_code");
  endtask : t_code
  // non-trap words, stalled words and the extra decoded forms
  task automatic t_other();
    run(rw(6'h26, 10'h000), 64'h1, 64'h2, 1'b0, 1'b0);
    run(iw(5'h01, 16'h0000), 64'h1, 64'h0, 1'b0, 1'b0);
    run(32'h3C000000, 64'h1, 64'h2, 1'b0, 1'b0);
    quiet(rw(`FN_NE_REG, 10'h000), 64'h1, 64'h2);
    run(rw(`FN_EQ_REG, 10'h000), 64'h9, 64'h9, 1'b1, 1'b1);
    run(rw(`FN_GE_S_REG, 10'h000), '1, 64'h1, 1'b0, 1'b1);
    run(iw(`SEL_GE_S_IMM, 16'hFFFF), 64'h0, 64'h0, 1'b1, 1'b1);
    run(iw(`SEL_EQ_IMM, 16'h8000), 64'hFFFFFFFFFFFF8000, 64'h0, 1'b1, 1'b1);
    rest("t_other");
  endtask : t_other
  // reset in mid-run clears a standing trap pulse; the next issue still works
  task automatic t_reset();
    PART.issue(rw(`FN_NE_REG, 10'h000), 64'h1, 64'h2);
    chk("trap_taken before reset", 1'b1, trap_taken);
    rst_b = 1'b0;
    PART.idle();
    chk("trap_taken in reset", 1'b0, trap_taken);
    chk("is_trap_instr in reset", 1'b0, is_trap_instr);
    rst_b = 1'b1;
    run(rw(`FN_NE_REG, 10'h000), 64'h3, 64'h4, 1'b1, 1'b1);
    rest("t_reset");
  endtask : t_reset
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  // hang guard, far beyond the few dozen cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 400) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_reg();
    t_imm();
    t_code();
    t_other();
    t_reset();
    results();
  end
endmodule : conditional_trap_evaluator_tb

//--- verif/issue_model.sv
// issue-stage model feeding trap words to the evaluator
`timescale 1ns/100ps
module issue_model (
  input wire logic clk,
  output logic issue_valid,
  output logic [31:0] instr_word,
  output logic [63:0] op_a,
  output logic [63:0] op_b
);
  // quiet start, valid low before reset ends
  initial begin
    issue_valid = 1'b0;
    instr_word = 32'h0;
    op_a = 64'h0;
    op_b = 64'h0;
  end
  // one word per cycle, held through the taking edge
  task automatic issue(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b);
    issue_valid = 1'b1;
    instr_word = w;
    op_a = a;
    op_b = b;
    @(posedge clk);
    #1;
  endtask : issue
  // trap word on the lines with valid low, which the unit must ignore
  task automatic stall(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b);
    issue_valid = 1'b0;
    instr_word = w;
    op_a = a;
    op_b = b;
    @(posedge clk);
    #1;
  endtask : stall
  // released lines flip so stale operands never look live
  task automatic idle();
    issue_valid = 1'b0;
    instr_word = ~instr_word;
    op_a = ~op_a;
    op_b = ~op_b;
    @(posedge clk);
    #1;
  endtask : idle
endmodule : issue_model
